/* include/tca_defines.svh */
// constants for the temperature conversion and alarm block
`ifndef TCA_DEFINES_SVH
`define TCA_DEFINES_SVH

// command bytes decoded by this block
`define TCA_CMD_CONVERT   8'h44
`define TCA_CMD_ALM_SRCH  8'hEC

// scratchpad byte indices
`define TCA_SP_TEMP_LSB   4'h0
`define TCA_SP_TEMP_MSB   4'h1
`define TCA_SP_UPPER      4'h2
`define TCA_SP_LOWER      4'h3
`define TCA_SP_CONFIG     4'h4

// configuration byte layout
`define TCA_CFG_RES_HI    6
`define TCA_CFG_RES_LO    5

// resolution codes, {select_high, select_low}
`define TCA_RES_9         2'b00
`define TCA_RES_10        2'b01
`define TCA_RES_11        2'b10
`define TCA_RES_12        2'b11

// reset values
`define TCA_TEMP_RESET    16'h0550
`define TCA_BYTE_ZERO     8'h00

// timing: longest conversion at 12 bits, clock in kHz
`define TCA_CONV12_MS     750
`define TCA_CLK_KHZ       125000
`define TCA_CNT_W         27

`endif

/* include/tca_pkg.sv */
// types shared by the temperature conversion and alarm block
`include "tca_defines.svh"

package tca_pkg;

    typedef enum logic [0:0] {
        TCA_IDLE,
        TCA_CONVERT
    } tca_state_e;

    typedef struct packed {
        tca_state_e             state;
        logic [`TCA_CNT_W-1:0]  count;
        logic [15:0]            temperature;
        logic [7:0]             upper;
        logic [7:0]             lower;
        logic [1:0]             res;
        logic                   nv_loaded;
        logic                   alarm;
        logic                   busy;
        logic                   conv_done;
        logic                   slot_bit;
        logic                   slot_valid;
        logic                   search_respond;
        logic [7:0]             sp_rdata;
        logic                   supply_ff1;
        logic                   supply_ff2;
        logic                   supply_ext;
    } tca_top_s;

endpackage

/* logic/tca_quantize.sv */
// trims a raw sensor code to the resolution and sign-extends it
`timescale 1ns/1ps
`default_nettype none
`include "tca_defines.svh"

module tca_quantize
    import tca_pkg::*;
(
    input  wire logic [11:0] raw,
    input  wire logic [1:0]  res,
    output logic      [15:0] code
);

    logic [10:0] body;

    // undefined low bits are forced to zero so readback is stable
    always_comb
    begin
        body = raw[10:0];
        case (res)
            `TCA_RES_9:  body[2:0] = 3'h0;
            `TCA_RES_10: body[1:0] = 2'h0;
            `TCA_RES_11: body[0]   = 1'b0;
            default:     body      = raw[10:0];
        endcase
        // bits 15..11 all repeat the sign
        code = {{5{raw[11]}}, body};
    end

endmodule

`default_nettype wire

/* logic/tca_limit_cmp.sv */
// signed compare of the temperature window against one limit
`timescale 1ns/1ps
`default_nettype none

module tca_limit_cmp
    import tca_pkg::*;
#(
    parameter bit UPPER = 1'b1
)
(
    input  wire logic [7:0] temp_win,
    input  wire logic [7:0] limit,
    output logic            hit
);

    // both sides signed so negative limits order correctly
    always_comb
    begin
        if (UPPER)
            hit = $signed(temp_win) >= $signed(limit);
        else
            hit = $signed(temp_win) <= $signed(limit);
    end

endmodule

`default_nettype wire

/* logic/tca_top.sv */
// temperature conversion, result register and alarm flag
`timescale 1ns/1ps
`default_nettype none
`include "tca_defines.svh"

// Behaviour
// - resolution nine to twelve bits selectable
// - twelve-bit resolution in reset, then nonvolatile setting
// - idle until convert command byte arrives
// - store result, then back to idle
// - read slot answers 0 busy, 1 done
// - result is sign-extended sixteen-bit two's complement
// - bits fifteen to eleven carry sign
// - bit zero weighs one sixteenth degree
// - low bits undefined below twelve bits
// - result resets to eighty-five degrees
// - eight-bit signed limits at bytes two, three
// - limits and resolution kept nonvolatile
// - compare uses result bits eleven to four
// - alarm when at or below lower or at or above upper
// - alarm re-evaluated after every conversion
// - alarm search answered only when flagged
// - unique sixty-four-bit identification code held
// - config byte four, select bits default one
module tca_top
    import tca_pkg::*;
#(
    parameter int          CONV12_CYCLES = `TCA_CONV12_MS * `TCA_CLK_KHZ,
    // identification code default is an arbitrary value
    parameter logic [63:0] ID_CODE       = 64'h0123_4567_89AB_CDEF
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        read_slot,
    input  wire logic        sp_wr,
    input  wire logic        sp_rd,
    input  wire logic [3:0]  sp_index,
    input  wire logic [7:0]  sp_wdata,
    input  wire logic [11:0] sensor_code,
    input  wire logic [7:0]  nv_upper,
    input  wire logic [7:0]  nv_lower,
    input  wire logic [7:0]  nv_config,
    input  wire logic        supply_pin,
    output logic [15:0]      temperature,
    output logic [7:0]       upper_alarm_limit,
    output logic [7:0]       lower_alarm_limit,
    output logic [7:0]       config_byte,
    output logic             busy,
    output logic             conv_done,
    output logic             slot_bit,
    output logic             slot_valid,
    output logic             alarm_flag,
    output logic             search_respond,
    output logic [7:0]       sp_rdata,
    output logic             supply_external,
    output logic [63:0]      rom_code
);

    localparam logic [`TCA_CNT_W-1:0] FULL_CNT =
        `TCA_CNT_W'(CONV12_CYCLES);

    tca_top_s st;
    tca_top_s next_st;
    logic [15:0] quant;
    logic [63:0] id_reg;
    logic        hit_upper;
    logic        hit_lower;
    logic        start_cmd;
    logic [1:0]  shift_by;

    // sensor code trimmed to the active resolution
    tca_quantize u_quant (
        .raw  (sensor_code),
        .res  (st.res),
        .code (quant)
    );

    // only bits 11..4 of the fresh result meet the 8-bit limits
    tca_limit_cmp #(.UPPER(1'b1)) u_cmp_upper (
        .temp_win (quant[11:4]),
        .limit    (st.upper),
        .hit      (hit_upper)
    );

    tca_limit_cmp #(.UPPER(1'b0)) u_cmp_lower (
        .temp_win (quant[11:4]),
        .limit    (st.lower),
        .hit      (hit_lower)
    );

    assign start_cmd = cmd_valid && (cmd_byte == `TCA_CMD_CONVERT);
    assign shift_by  = 2'(`TCA_RES_12 - st.res);

    // next-state logic for the whole block
    always_comb
    begin
        next_st            = st;
        next_st.conv_done  = 1'b0;
        next_st.slot_valid = 1'b0;
        // supply sense passes three flops before use
        next_st.supply_ff1 = supply_pin;
        next_st.supply_ff2 = st.supply_ff1;
        next_st.supply_ext = st.supply_ff2;

        // one-time load of the nonvolatile copies after reset
        if (!st.nv_loaded)
        begin
            next_st.nv_loaded = 1'b1;
            next_st.upper     = nv_upper;
            next_st.lower     = nv_lower;
            next_st.res       = {nv_config[`TCA_CFG_RES_HI],
                                 nv_config[`TCA_CFG_RES_LO]};
        end

        // scratchpad writes land in bytes 2..4 only
        if (sp_wr && st.nv_loaded)
        begin
            case (sp_index)
                `TCA_SP_UPPER:  next_st.upper = sp_wdata;
                `TCA_SP_LOWER:  next_st.lower = sp_wdata;
                `TCA_SP_CONFIG: next_st.res   =
                    {sp_wdata[`TCA_CFG_RES_HI],
                     sp_wdata[`TCA_CFG_RES_LO]};
                default:        next_st.res   = next_st.res;
            endcase
        end

        // scratchpad readback, answered one cycle later
        if (sp_rd)
        begin
            case (sp_index)
                `TCA_SP_TEMP_LSB: next_st.sp_rdata = st.temperature[7:0];
                `TCA_SP_TEMP_MSB: next_st.sp_rdata = st.temperature[15:8];
                `TCA_SP_UPPER:    next_st.sp_rdata = st.upper;
                `TCA_SP_LOWER:    next_st.sp_rdata = st.lower;
                `TCA_SP_CONFIG:   next_st.sp_rdata = config_image(st.res);
                default:          next_st.sp_rdata = `TCA_BYTE_ZERO;
            endcase
        end

        // status answer to a read slot; under bus power the master
        // does not poll, so the same answer is harmless there
        if (read_slot)
        begin
            next_st.slot_valid = 1'b1;
            next_st.slot_bit   = (st.state == TCA_IDLE);
        end

        // alarm search sees the flag as it stands
        if (cmd_valid && (cmd_byte == `TCA_CMD_ALM_SRCH))
            next_st.search_respond = st.alarm;
        else if (cmd_valid)
            next_st.search_respond = 1'b0;

        case (st.state)
            TCA_IDLE:
            begin
                // nothing runs until the convert byte
                if (start_cmd)
                begin
                    next_st.state = TCA_CONVERT;
                    next_st.busy  = 1'b1;
                    // coarser resolution finishes proportionally sooner
                    next_st.count = FULL_CNT >> shift_by;
                end
            end
            TCA_CONVERT:
            begin
                if (st.count <= `TCA_CNT_W'(1))
                begin
                    next_st.state       = TCA_IDLE;
                    next_st.busy        = 1'b0;
                    next_st.conv_done   = 1'b1;
                    next_st.temperature = quant;
                    next_st.alarm       = hit_upper || hit_lower;
                end
                else
                    next_st.count = st.count - `TCA_CNT_W'(1);
            end
            default:
            begin
                next_st.state = TCA_IDLE;
                next_st.busy  = 1'b0;
            end
        endcase
    end

    // config byte image: reserved bits read as zero
    function automatic logic [7:0] config_image(input logic [1:0] r);
        logic [7:0] b;
        b                  = `TCA_BYTE_ZERO;
        b[`TCA_CFG_RES_HI] = r[1];
        b[`TCA_CFG_RES_LO] = r[0];
        return b;
    endfunction

    // state register; reset puts the block in idle at 12 bits
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st             <= '0;
            st.state       <= TCA_IDLE;
            st.temperature <= `TCA_TEMP_RESET;
            st.res         <= `TCA_RES_12;
            st.slot_bit    <= 1'b1;
            id_reg         <= ID_CODE;
        end
        else
        begin
            st     <= next_st;
            id_reg <= id_reg;
        end
    end

    // outputs straight from the state flops
    assign temperature       = st.temperature;
    assign upper_alarm_limit = st.upper;
    assign lower_alarm_limit = st.lower;
    assign config_byte       = config_image(st.res);
    assign busy              = st.busy;
    assign conv_done         = st.conv_done;
    assign slot_bit          = st.slot_bit;
    assign slot_valid        = st.slot_valid;
    assign alarm_flag        = st.alarm;
    assign search_respond    = st.search_respond;
    assign sp_rdata          = st.sp_rdata;
    assign supply_external   = st.supply_ext;
    assign rom_code          = id_reg;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reset_temp: assert property ($rose(resetn) |->
        temperature == `TCA_TEMP_RESET)
        else $error("result not at power-on code after reset");

    a_reset_res: assert property ($rose(resetn) |->
        config_byte[`TCA_CFG_RES_HI] && config_byte[`TCA_CFG_RES_LO])
        else $error("resolution not twelve bits after reset");

    a_start_busy: assert property (
        (start_cmd && !busy && st.nv_loaded) |=> busy)
        else $error("convert command did not start a conversion");

    a_idle_stays: assert property (
        (!busy && !start_cmd) |=> !busy)
        else $error("conversion started without command");

    a_done_idle: assert property (conv_done |->
        !busy && $past(busy))
        else $error("done without a conversion ending");

    a_slot_answer: assert property (read_slot |=>
        slot_valid && (slot_bit == !$past(busy)))
        else $error("read slot answer does not match status");

    a_sign_bits: assert property (
        temperature[15:11] == {5{temperature[11]}})
        else $error("sign bits disagree");

    a_low_bits: assert property ((conv_done &&
        config_byte[`TCA_CFG_RES_HI:`TCA_CFG_RES_LO] == `TCA_RES_9) |->
        temperature[2:0] == 3'h0)
        else $error("undefined bits not cleared at nine bits");

    a_alarm_eval: assert property (conv_done |->
        alarm_flag == (($signed(temperature[11:4]) >= $signed(st.upper))
                    || ($signed(temperature[11:4]) <= $signed(st.lower))))
        else $error("alarm flag does not match result and limits");

    a_alarm_hold: assert property (
        !conv_done |-> $stable(alarm_flag))
        else $error("alarm flag changed outside a conversion end");

    a_search_gate: assert property (
        $rose(search_respond) |-> $past(alarm_flag))
        else $error("search answered without alarm");

    a_search_clear: assert property (
        (cmd_valid && cmd_byte != `TCA_CMD_ALM_SRCH) |=> !search_respond)
        else $error("search answer kept after another command");

    a_limit_write: assert property (
        (sp_wr && st.nv_loaded && sp_index == `TCA_SP_UPPER) |=>
        upper_alarm_limit == $past(sp_wdata))
        else $error("upper limit write lost");

    c_conv_done:   cover property (conv_done);
    c_alarm_set:   cover property ($rose(alarm_flag));
    c_slot_busy:   cover property (slot_valid && !slot_bit);
    c_search_resp: cover property (search_respond);

endmodule

`default_nettype wire

/* test/tca_master_model.sv */
// bus master stand-in driving the command, slot and scratchpad strobes
`timescale 1ns/1ps
`default_nettype none

module tca_master_model
    import tca_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       supply_external,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            read_slot,
    output logic            sp_wr,
    output logic            sp_rd,
    output logic [3:0]      sp_index,
    output logic [7:0]      sp_wdata
);
    // idle levels from time zero
    initial
    begin
        {cmd_valid, read_slot, sp_wr, sp_rd} = 4'b0000;
        {cmd_byte, sp_wdata, sp_index} = 20'h0_0000;
    end

    // one-cycle request; qualifiers drop and data inverts after so stale data never matches
    task automatic strobe(input logic [3:0] sel, input logic [7:0] b,
                          input logic [3:0] idx);
        @(posedge clk);
        #1;
        {cmd_valid, read_slot, sp_wr, sp_rd} = sel;
        {cmd_byte, sp_wdata, sp_index} = {b, b, idx};
        @(posedge clk);
        #1;
        {cmd_valid, read_slot, sp_wr, sp_rd} = 4'b0000;
        {cmd_byte, sp_wdata, sp_index} = ~{b, b, idx};
    endtask

    // conversions only start on a command byte
    task automatic cmd(input logic [7:0] b);
        strobe(4'b1000, b, 4'h0);
    endtask

    // no polling when the device runs from bus power
    task automatic slot();
        if (supply_external === 1'b1)
            strobe(4'b0100, 8'h00, 4'h0);
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        strobe(4'b0010, d, i);
    endtask

    task automatic rd(input logic [3:0] i);
        strobe(4'b0001, 8'h00, i);
    endtask
endmodule

`default_nettype wire

/* test/temp_conversion_alarm_logic_tb.sv */
// self-checking bench for the conversion and alarm block
`timescale 1ns/1ps
`default_nettype none
`include "tca_defines.svh"

module temp_conversion_alarm_logic_tb
    import tca_pkg::*;
;
    localparam logic [63:0] ID     = 64'h5a5a_0f0f_1234_9876; // arbitrary
    localparam logic [7:0]  NV_UP  = 8'h3C;
    localparam logic [7:0]  NV_LO  = 8'h81;
    localparam logic [7:0]  NV_CFG = 8'h3F;
    localparam logic [7:0]  LIM_UP = 8'h14;
    localparam logic [7:0]  LIM_LO = 8'hF6;
    logic        clk = 1'b0;
    logic        resetn;
    logic [11:0] sensor_code;
    logic        supply_pin;
    wire logic   cmd_valid, read_slot, sp_wr, sp_rd;
    wire logic [7:0] cmd_byte, sp_wdata;
    wire logic [3:0] sp_index;
    logic [15:0] temperature;
    logic [7:0]  upper_alarm_limit, lower_alarm_limit, config_byte, sp_rdata;
    logic        busy, conv_done, slot_bit, slot_valid, alarm_flag;
    logic        search_respond, supply_external;
    logic [63:0] rom_code;
    logic [18:0] exp_q[$];
    logic        rd_seen = 1'b0;
    logic        sr_seen = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;

    always #4 clk = ~clk;

    tca_top #(.CONV12_CYCLES(64), .ID_CODE(ID)) dut (
        .clk, .resetn, .cmd_valid, .cmd_byte, .read_slot, .sp_wr, .sp_rd,
        .sp_index, .sp_wdata, .sensor_code, .nv_upper(NV_UP),
        .nv_lower(NV_LO), .nv_config(NV_CFG), .supply_pin, .temperature,
        .upper_alarm_limit, .lower_alarm_limit, .config_byte, .busy,
        .conv_done, .slot_bit, .slot_valid, .alarm_flag, .search_respond,
        .sp_rdata, .supply_external, .rom_code);

    tca_master_model m (
        .clk, .supply_external, .cmd_valid, .cmd_byte, .read_slot, .sp_wr,
        .sp_rd, .sp_index, .sp_wdata);

    task automatic check(input string name, input logic [16:0] seen,
                         input logic [16:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic push(input logic [1:0] k, input logic [16:0] v);
        exp_q.push_back({k, v});
    endtask

    // empty queue or wrong kind yields x, which never matches
    function automatic logic [16:0] pop(input logic [1:0] k);
        logic [18:0] e;
        if (exp_q.size() == 0)
            return 'x;
        e = exp_q.pop_front();
        return (e[18:17] == k) ? e[16:0] : 'x;
    endfunction

    // trimmed, sign-extended code; undefined low bits taken as zero
    function automatic logic [15:0] exp_temp(input logic [11:0] raw,
                                             input logic [1:0] res);
        logic [11:0] v;
        v = raw & ~(12'h007 >> res);
        return {{4{v[11]}}, v};
    endfunction

    // signed window of bits 11:4 against both limits
    function automatic logic exp_alarm(input logic [15:0] t);
        return ($signed(t[11:4]) <= $signed(LIM_LO)) ||
               ($signed(t[11:4]) >= $signed(LIM_UP));
    endfunction

    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge clk)
    begin
        rd_seen <= (sp_rd === 1'b1);
        sr_seen <= (cmd_valid === 1'b1) && (cmd_byte === `TCA_CMD_ALM_SRCH);
        if (conv_done === 1'b1)
            check("result", {alarm_flag, temperature}, pop(2'd0));
        if (slot_valid === 1'b1)
            check("slot bit", {16'h0000, slot_bit}, pop(2'd1));
        if (rd_seen)
            check("read data", {9'h000, sp_rdata}, pop(2'd2));
        if (sr_seen)
            check("search", {16'h0000, search_respond}, pop(2'd3));
    end

    // watchdog, far beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    initial
    begin : main
        logic [7:0]  rd_exp [4];
        logic [3:0]  rd_idx [4];
        logic [11:0] codes [4];
        logic [15:0] t;
        logic [1:0]  res;
        int          n;
        rd_exp = '{8'h60, 8'h50, 8'h05, 8'h00};
        rd_idx = '{4'h4, 4'h0, 4'h1, 4'h5};
        // both limits hit exactly, then clear, then just below upper
        codes = '{12'h140, 12'hF60, 12'h000, 12'h13F};
        resetn = 1'b0;
        sensor_code = 12'h000;
        supply_pin = 1'b1;
        void'($urandom(32'hc76d));
        repeat (4) @(posedge clk);
        #1;
        check("reset temp", {1'b0, temperature}, {1'b0, `TCA_TEMP_RESET});
        check("reset config", {9'h000, config_byte}, 17'h0_0060);
        check("id code", {16'h0000, rom_code === ID}, 17'h0_0001);
        resetn = 1'b1;
        repeat (2) @(posedge clk);
        // nonvolatile copies appear at bytes two to four
        push(2'd2, {9'h000, NV_UP});
        m.rd(`TCA_SP_UPPER);
        push(2'd2, {9'h000, NV_LO});
        m.rd(`TCA_SP_LOWER);
        push(2'd2, {9'h000, NV_CFG & 8'h60});
        m.rd(`TCA_SP_CONFIG);
        // reserved config bits and read-only bytes refuse writes
        m.wr(`TCA_SP_CONFIG, 8'hFF);
        m.wr(`TCA_SP_TEMP_LSB, 8'hAA);
        for (int i = 0; i < 4; i++)
        begin
            push(2'd2, {9'h000, rd_exp[i]});
            m.rd(rd_idx[i]);
        end
        m.wr(`TCA_SP_UPPER, LIM_UP);
        m.wr(`TCA_SP_LOWER, LIM_LO);
        check("upper", 17'(upper_alarm_limit), 17'(LIM_UP));
        check("lower", 17'(lower_alarm_limit), 17'(LIM_LO));
        // every resolution with random codes, then the boundary table
        for (int i = 0; i < 8; i++)
        begin
            res = 2'(i);
            m.wr(`TCA_SP_CONFIG, {1'b0, res, 5'b0_0000});
            sensor_code = (i < 4) ? 12'($urandom) : codes[i - 4];
            t = exp_temp(sensor_code, res);
            m.cmd(`TCA_CMD_CONVERT);
            check("busy", 17'(busy), 17'h0_0001);
            push(2'd1, 17'h0_0000);
            m.slot();
            push(2'd0, {exp_alarm(t), t});
            m.cmd(`TCA_CMD_CONVERT);
            n = 0;
            while (conv_done !== 1'b1 && n < 300)
            begin
                @(posedge clk);
                n++;
            end
            check("conversion ends", {16'h0000, n < 300}, 17'h0_0001);
            check("idle", 17'(busy), 17'h0_0000);
            push(2'd1, 17'h0_0001);
            m.slot();
            push(2'd3, {16'h0000, exp_alarm(t)});
            m.cmd(`TCA_CMD_ALM_SRCH);
            // a restarted conversion would show a stray result here
            repeat (80) @(posedge clk);
        end
        // bus power: sense drops and the master stops polling
        check("supply", 17'(supply_external), 17'h0_0001);
        #1;
        supply_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("bus power", 17'(supply_external), 17'h0_0000);
        m.slot();
        repeat (4) @(posedge clk);
        // mid-run reset reloads the nonvolatile copies
        #1;
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("reload temp", 17'(temperature), 17'(`TCA_TEMP_RESET));
        resetn = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("nv up", 17'(upper_alarm_limit), 17'(NV_UP));
        check("nv lo", 17'(lower_alarm_limit), 17'(NV_LO));
        check("nv cfg", 17'(config_byte), 17'(NV_CFG & 8'h60));
        check("pending", 17'(exp_q.size()), 17'h0_0000);
        stop_test();
    end
endmodule

`default_nettype wire
